// *** mcr_consts.vh ***
`ifndef MCR_CONSTS_VH
`define MCR_CONSTS_VH

// Register offsets
`define MCR_OFS_VENDOR        8'h00
`define MCR_OFS_DEVICE        8'h01
`define MCR_OFS_CHAN_EN       8'h04
`define MCR_OFS_SKIP          8'h05
`define MCR_OFS_POLARITY      8'h06
`define MCR_OFS_OFFSET        8'h07
`define MCR_OFS_CM            8'h08
`define MCR_OFS_TIMEOUT       8'h0F
`define MCR_OFS_VGAIN1        8'h10
`define MCR_OFS_VGAIN2        8'h11
`define MCR_OFS_VGAIN3        8'h12
`define MCR_OFS_VGAIN4        8'h13
`define MCR_OFS_IGAIN1        8'h20
`define MCR_OFS_IGAIN2        8'h21
`define MCR_OFS_IGAIN3        8'h22
`define MCR_OFS_IGAIN4        8'h23
`define MCR_OFS_LOCK          8'h24

// Field positions
`define MCR_CHAN_LO           3:0
`define MCR_GND_BIT           7
`define MCR_IMON2_BIT         5
`define MCR_IMON1_BIT         4
`define MCR_SKIP_START        7:4
`define MCR_SKIP_END          3:0
`define MCR_ALT_BIT           7
`define MCR_OFFSET_FLD        1:0
`define MCR_CM_FLD            3:0
`define MCR_TMO_BIT           7
`define MCR_GAIN_FLD          5:1
`define MCR_LOCK_WR_BIT       1
`define MCR_LOCK_ALL_BIT      0

// Reset values
`define MCR_RST_CHAN_EN       8'h0F
`define MCR_RST_SKIP          8'h00
`define MCR_RST_ALT           1'h0
`define MCR_RST_OFFSET        2'h0
`define MCR_RST_CM            4'h7
`define MCR_RST_TMO           1'h0
`define MCR_RST_GAIN          5'h00
`define MCR_RST_LOCK          2'h0

// Identity codes, arbitrary values
`define MCR_VENDOR_CODE       8'hA5
`define MCR_DEVICE_CODE       8'h5A

`endif

// *** mcr_stage_reg.v ***
`timescale 1ns/1ps
`default_nettype none

// Written copy plus applied copy loaded at cycle boundary
module mcr_stage_reg #(
  parameter       W   = 8,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  // Clock and reset
  input  wire         i_mclk,
  input  wire         i_rstn,
  // Write and apply
  input  wire         i_wr,
  input  wire [W-1:0] i_wdata,
  input  wire         i_apply,
  // Values
  output reg  [W-1:0] o_written_q,
  output reg  [W-1:0] o_applied_q
);

  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_written_q <= RST;
      o_applied_q <= RST;
    end else begin
      if (i_wr) begin
        o_written_q <= i_wdata;
      end
      if (i_apply) begin
        o_applied_q <= i_wr ? i_wdata : o_written_q;
      end
    end
  end

endmodule // mcr_stage_reg

`default_nettype wire

// *** mcr_config_regs.v ***
`timescale 1ns/1ps
`default_nettype none
`include "mcr_consts.vh"

module mcr_config_regs (
  // Clock and reset
  input  wire       i_mclk,
  input  wire       i_rstn,
  // Register access from the serial engine
  input  wire       i_wr_stb,
  input  wire       i_rd_stb,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  output reg  [7:0] o_rdata,
  output reg        o_rd_valid,
  output reg        o_bus_respond,
  output reg        o_wr_allowed,
  // Multiplexer step
  input  wire       i_mux_step_pulse,
  output reg        o_cycle_start,
  output reg        o_output_drive,
  output reg  [3:0] o_slot_index,
  output reg        o_reversed,
  // Applied configuration
  output reg  [7:0] o_channel_enable,
  output reg  [3:0] o_skip_start,
  output reg  [3:0] o_skip_end,
  output reg        o_alt_mode,
  output reg  [1:0] o_offset_sel,
  output reg  [3:0] o_common_mode,
  output reg        o_timeout_disable,
  output reg  [4:0] o_vgain_ch1,
  output reg  [4:0] o_vgain_ch2,
  output reg  [4:0] o_vgain_ch3,
  output reg  [4:0] o_vgain_ch4,
  output reg  [4:0] o_igain_ch1,
  output reg  [4:0] o_igain_ch2,
  output reg  [4:0] o_igain_ch3,
  output reg  [4:0] o_igain_ch4
);

  // Masked channel enable value, only defined bits kept
  localparam [7:0] CHAN_MASK = 8'hBF;

  reg  [1:0] lock_q;
  reg  [1:0] lock_d;
  reg  [1:0] offset_q;
  reg  [3:0] cm_q;
  reg        tmo_q;
  reg  [4:0] vgain_q [0:3];
  reg  [4:0] igain_q [0:3];
  reg  [5:0] step_q;
  reg  [5:0] step_d;
  reg        rev_q;

  wire       lock_wr  = lock_q[`MCR_LOCK_WR_BIT] | lock_q[`MCR_LOCK_ALL_BIT];
  wire       lock_all = lock_q[`MCR_LOCK_ALL_BIT];
  wire       wr_ok    = i_wr_stb & ~lock_wr;
  wire       rd_ok    = i_rd_stb & ~lock_all;

  wire       wr_chan  = wr_ok & (i_addr == `MCR_OFS_CHAN_EN);
  wire       wr_skip  = wr_ok & (i_addr == `MCR_OFS_SKIP);
  wire       wr_pol   = wr_ok & (i_addr == `MCR_OFS_POLARITY);

  wire [7:0] chan_w;
  wire [7:0] chan_a;
  wire [7:0] skip_w;
  wire [7:0] skip_a;
  wire       alt_w;
  wire       alt_a;
  wire       apply;

  // Staged settings, applied at the cycle boundary
  mcr_stage_reg #(.W(8), .RST(`MCR_RST_CHAN_EN)) u_chan (
    .i_mclk      (i_mclk),
    .i_rstn      (i_rstn),
    .i_wr        (wr_chan),
    .i_wdata     (i_wdata & CHAN_MASK),
    .i_apply     (apply),
    .o_written_q (chan_w),
    .o_applied_q (chan_a)
  );

  mcr_stage_reg #(.W(8), .RST(`MCR_RST_SKIP)) u_skip (
    .i_mclk      (i_mclk),
    .i_rstn      (i_rstn),
    .i_wr        (wr_skip),
    .i_wdata     (i_wdata),
    .i_apply     (apply),
    .o_written_q (skip_w),
    .o_applied_q (skip_a)
  );

  mcr_stage_reg #(.W(1), .RST(`MCR_RST_ALT)) u_alt (
    .i_mclk      (i_mclk),
    .i_rstn      (i_rstn),
    .i_wr        (wr_pol),
    .i_wdata     (i_wdata[`MCR_ALT_BIT]),
    .i_apply     (apply),
    .o_written_q (alt_w),
    .o_applied_q (alt_a)
  );

  // Cycle length from applied settings
  wire [2:0] nchan = {2'h0, chan_a[0]} + {2'h0, chan_a[1]}
                   + {2'h0, chan_a[2]} + {2'h0, chan_a[3]};
  wire [3:0] nslot = {nchan, 1'b0} + {3'h0, chan_a[`MCR_IMON1_BIT]}
                   + {3'h0, chan_a[`MCR_IMON2_BIT]} + {3'h0, chan_a[`MCR_GND_BIT]};
  wire [3:0] sk_st = skip_a[`MCR_SKIP_START];
  wire [3:0] sk_en = skip_a[`MCR_SKIP_END];
  wire [5:0] total = {2'h0, sk_st} + {2'h0, nslot} + {2'h0, sk_en};
  wire [5:0] last  = (total == 6'h00) ? 6'h00 : total - 6'h01;
  wire [5:0] slot_end = {2'h0, sk_st} + {2'h0, nslot};

  assign apply = i_mux_step_pulse & (step_q == last);

  // Step counter within a mux cycle
  always @* begin
    step_d = step_q;
    if (i_mux_step_pulse) begin
      step_d = apply ? 6'h00 : step_q + 6'h01;
    end
  end

  // Lock bits only ever set, cleared by power-up reset
  always @* begin
    lock_d = lock_q;
    if (wr_ok && (i_addr == `MCR_OFS_LOCK)) begin
      lock_d = lock_q | i_wdata[1:0];
    end
  end

  integer k;

  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      lock_q   <= `MCR_RST_LOCK;
      offset_q <= `MCR_RST_OFFSET;
      cm_q     <= `MCR_RST_CM;
      tmo_q    <= `MCR_RST_TMO;
      step_q   <= 6'h00;
      rev_q    <= 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
        vgain_q[k] <= `MCR_RST_GAIN;
        igain_q[k] <= `MCR_RST_GAIN;
      end
    end else begin
      lock_q <= lock_d;
      step_q <= step_d;
      if (apply) begin
        rev_q <= alt_a ? ~rev_q : 1'b0;
      end
      if (wr_ok) begin
        case (i_addr)
          `MCR_OFS_OFFSET: begin
            offset_q <= i_wdata[`MCR_OFFSET_FLD];
          end
          `MCR_OFS_CM: begin
            cm_q <= i_wdata[`MCR_CM_FLD];
          end
          `MCR_OFS_TIMEOUT: begin
            tmo_q <= i_wdata[`MCR_TMO_BIT];
          end
          default: begin
            for (k = 0; k < 4; k = k + 1) begin
              if (i_addr == (`MCR_OFS_VGAIN1 + k[7:0])) begin
                vgain_q[k] <= i_wdata[`MCR_GAIN_FLD];
              end
              if (i_addr == (`MCR_OFS_IGAIN1 + k[7:0])) begin
                igain_q[k] <= i_wdata[`MCR_GAIN_FLD];
              end
            end
          end
        endcase
      end
    end
  end

  // Read mux, reserved bits zero
  reg [7:0] rd_val;
  always @* begin
    rd_val = 8'h00;
    case (i_addr)
      `MCR_OFS_VENDOR:   rd_val = `MCR_VENDOR_CODE;
      `MCR_OFS_DEVICE:   rd_val = `MCR_DEVICE_CODE;
      `MCR_OFS_CHAN_EN:  rd_val = chan_w;
      `MCR_OFS_SKIP:     rd_val = skip_w;
      `MCR_OFS_POLARITY: rd_val = {alt_w, 7'h00};
      `MCR_OFS_OFFSET:   rd_val = {6'h00, offset_q};
      `MCR_OFS_CM:       rd_val = {4'h0, cm_q};
      `MCR_OFS_TIMEOUT:  rd_val = {tmo_q, 7'h00};
      `MCR_OFS_VGAIN1:   rd_val = {2'h0, vgain_q[0], 1'b0};
      `MCR_OFS_VGAIN2:   rd_val = {2'h0, vgain_q[1], 1'b0};
      `MCR_OFS_VGAIN3:   rd_val = {2'h0, vgain_q[2], 1'b0};
      `MCR_OFS_VGAIN4:   rd_val = {2'h0, vgain_q[3], 1'b0};
      `MCR_OFS_IGAIN1:   rd_val = {2'h0, igain_q[0], 1'b0};
      `MCR_OFS_IGAIN2:   rd_val = {2'h0, igain_q[1], 1'b0};
      `MCR_OFS_IGAIN3:   rd_val = {2'h0, igain_q[2], 1'b0};
      `MCR_OFS_IGAIN4:   rd_val = {2'h0, igain_q[3], 1'b0};
      `MCR_OFS_LOCK:     rd_val = {6'h00, lock_q};
      default:           rd_val = 8'h00;
    endcase
  end

  // Registered outputs
  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_rdata           <= 8'h00;
      o_rd_valid        <= 1'b0;
      o_bus_respond     <= 1'b1;
      o_wr_allowed      <= 1'b1;
      o_cycle_start     <= 1'b0;
      o_output_drive    <= 1'b0;
      o_slot_index      <= 4'h0;
      o_reversed        <= 1'b0;
      o_channel_enable  <= `MCR_RST_CHAN_EN;
      o_skip_start      <= 4'h0;
      o_skip_end        <= 4'h0;
      o_alt_mode        <= `MCR_RST_ALT;
      o_offset_sel      <= `MCR_RST_OFFSET;
      o_common_mode     <= `MCR_RST_CM;
      o_timeout_disable <= `MCR_RST_TMO;
      o_vgain_ch1       <= `MCR_RST_GAIN;
      o_vgain_ch2       <= `MCR_RST_GAIN;
      o_vgain_ch3       <= `MCR_RST_GAIN;
      o_vgain_ch4       <= `MCR_RST_GAIN;
      o_igain_ch1       <= `MCR_RST_GAIN;
      o_igain_ch2       <= `MCR_RST_GAIN;
      o_igain_ch3       <= `MCR_RST_GAIN;
      o_igain_ch4       <= `MCR_RST_GAIN;
    end else begin
      o_rd_valid <= rd_ok;
      if (rd_ok) begin
        o_rdata <= rd_val;
      end
      o_bus_respond     <= ~lock_d[`MCR_LOCK_ALL_BIT];
      o_wr_allowed      <= ~(|lock_d);
      o_cycle_start     <= apply;
      o_output_drive    <= (step_q >= {2'h0, sk_st}) && (step_q < slot_end) && (nslot != 4'h0);
      o_slot_index      <= step_q[3:0] - sk_st;
      o_reversed        <= rev_q;
      o_channel_enable  <= chan_a;
      o_skip_start      <= sk_st;
      o_skip_end        <= sk_en;
      o_alt_mode        <= alt_a;
      o_offset_sel      <= offset_q;
      o_common_mode     <= cm_q;
      o_timeout_disable <= tmo_q;
      o_vgain_ch1       <= vgain_q[0];
      o_vgain_ch2       <= vgain_q[1];
      o_vgain_ch3       <= vgain_q[2];
      o_vgain_ch4       <= vgain_q[3];
      o_igain_ch1       <= igain_q[0];
      o_igain_ch2       <= igain_q[1];
      o_igain_ch3       <= igain_q[2];
      o_igain_ch4       <= igain_q[3];
    end
  end

endmodule // mcr_config_regs

`default_nettype wire

// *** mcr_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module mcr_properties (
  // Clock, reset, register port
  input wire logic       i_mclk, i_rstn, i_wr_stb, i_rd_stb,
  input wire logic [7:0] i_addr, i_wdata, o_channel_enable,
  input wire logic       o_rd_valid, o_bus_respond, o_wr_allowed,
  // Applied settings
  input wire logic       o_cycle_start, o_alt_mode, o_timeout_disable,
  input wire logic [3:0] o_skip_start, o_skip_end,
  input wire logic [1:0] o_offset_sel,
  input wire logic [4:0] o_vgain_ch1, o_igain_ch4
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  wire logic wr_ok;
  assign wr_ok = i_wr_stb && o_wr_allowed;
  a_read_answered: assert property (
    i_rd_stb && o_bus_respond |=> o_rd_valid) else $error("read not answered");
  a_locked_silent: assert property (
    !o_bus_respond |-> ##1 !o_rd_valid && !o_wr_allowed) else $error("locked bus answered");
  a_lock_sticky: assert property (!o_wr_allowed |=> !o_wr_allowed)
    else $error("lock released");
  a_lock_cause: assert property (
    $fell(o_wr_allowed) |-> $past(i_wr_stb && i_addr == 8'h24)) else $error("lock without write");
  a_offset_now: assert property (
    wr_ok && i_addr == 8'h07 |=> ##1 o_offset_sel == $past(i_wdata[1:0], 2))
    else $error("offset not applied");
  a_timeout_now: assert property (
    wr_ok && i_addr == 8'h0F |=> ##1 o_timeout_disable == $past(i_wdata[7], 2))
    else $error("timeout bit not applied");
  a_vgain_now: assert property (
    wr_ok && i_addr == 8'h10 |=> ##1 o_vgain_ch1 == $past(i_wdata[5:1], 2))
    else $error("voltage gain not applied");
  a_igain_now: assert property (
    wr_ok && i_addr == 8'h23 |=> ##1 o_igain_ch4 == $past(i_wdata[5:1], 2))
    else $error("current gain not applied");
  a_staged_hold: assert property (
    !$stable({o_channel_enable, o_skip_start, o_skip_end, o_alt_mode})
    |-> o_cycle_start || $past(o_cycle_start)) else $error("staged value changed mid cycle");
  c_cycle: cover property (o_cycle_start);
  c_full_lock: cover property (!o_bus_respond);
  c_read_wlock: cover property (o_rd_valid && !o_wr_allowed);
endmodule // mcr_properties
bind mcr_config_regs mcr_properties u_props (.i_mclk, .i_rstn, .i_wr_stb, .i_rd_stb,
  .i_addr, .i_wdata, .o_channel_enable, .o_rd_valid, .o_bus_respond, .o_wr_allowed,
  .o_cycle_start, .o_alt_mode, .o_timeout_disable, .o_skip_start, .o_skip_end,
  .o_offset_sel, .o_vgain_ch1, .o_igain_ch4);
`default_nettype wire

// *** mcr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mcr_host_model (
  // Clock and read answer
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rd_valid,
  // Register requests
  output logic            o_wr_stb,
  output logic            o_rd_stb,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata
);
  initial begin
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    o_addr   = 8'h00;
    o_wdata  = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk) #1;
    o_addr = a;
    o_wdata = d;
    o_wr_stb = 1'b1;
    @(posedge i_mclk) #1;
    o_wr_stb = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge i_mclk) #1;
    o_addr = a;
    o_rd_stb = 1'b1;
    @(posedge i_mclk) #1;
    o_rd_stb = 1'b0;
    o_addr = ~a;
    d = i_rdata;
    v = i_rd_valid;
  endtask
endmodule // mcr_host_model
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk, rstn, step, v;
  logic [7:0] d, k;
  int n_mismatch, n_tests, cyc, n;
  wire logic wr_stb, rd_stb, rd_valid, bus_respond, wr_allowed, cyc_start, alt, tmo;
  wire logic [7:0] addr, wdata, rdata, chan;
  wire logic drv, rev;
  wire logic [3:0] s_start, s_end, slot, cm;
  wire logic [1:0] ofs;
  wire logic [4:0] vg [4];
  wire logic [4:0] ig [4];
  mcr_host_model host (.i_mclk(mclk), .i_rdata(rdata), .i_rd_valid(rd_valid),
    .o_wr_stb(wr_stb), .o_rd_stb(rd_stb), .o_addr(addr), .o_wdata(wdata));
  mcr_config_regs DUT (.i_mclk(mclk), .i_rstn(rstn), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rd_valid(rd_valid),
    .o_bus_respond(bus_respond), .o_wr_allowed(wr_allowed), .i_mux_step_pulse(step),
    .o_cycle_start(cyc_start), .o_output_drive(drv), .o_slot_index(slot), .o_reversed(rev),
    .o_channel_enable(chan), .o_skip_start(s_start), .o_skip_end(s_end), .o_alt_mode(alt),
    .o_offset_sel(ofs), .o_common_mode(cm), .o_timeout_disable(tmo),
    .o_vgain_ch1(vg[0]), .o_vgain_ch2(vg[1]), .o_vgain_ch3(vg[2]), .o_vgain_ch4(vg[3]),
    .o_igain_ch1(ig[0]), .o_igain_ch2(ig[1]), .o_igain_ch3(ig[2]), .o_igain_ch4(ig[3]));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      print_verdict;
    end
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, d, v);
    chk({7'h00, v}, 8'h01);
    chk(d, exp);
  endtask
  task settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task do_reset;
    @(posedge mclk) #1 rstn = 1'b0;
    repeat (3) @(posedge mclk);
    #1 rstn = 1'b1;
  endtask
  task step_cycle;
    n = 0;
    do begin
      @(posedge mclk) #1 step = 1'b1;
      @(posedge mclk) #1 step = 1'b0;
      n++;
    end while (cyc_start !== 1'b1 && n < 64);
  endtask
  task t_defaults;
    logic [15:0] tbl [16];
    tbl = '{16'h040F, 16'h0500, 16'h0600, 16'h0700, 16'h0807, 16'h0F00,
      16'h1000, 16'h1100, 16'h1200, 16'h1300, 16'h2000, 16'h2100, 16'h2200, 16'h2300,
      16'h2400, 16'h3000};
    foreach (tbl[i]) rchk(tbl[i][15:8], tbl[i][7:0]);
  endtask
  task t_immediate;
    for (k = 8'h00; k < 8'h04; k++) begin
      host.wr(8'h07, k);
      settle;
      chk({6'h00, ofs}, k);
    end
    host.wr(8'h0F, 8'hFF);
    settle;
    chk({7'h00, tmo}, 8'h01);
    rchk(8'h0F, 8'h80);
    for (k = 8'h00; k < 8'h04; k++) begin
      host.wr(8'h10 + k, 8'hFF);
      host.wr(8'h20 + k, 8'h3E);
      settle;
      chk({3'h0, vg[k[1:0]]}, 8'h1F);
      chk({3'h0, ig[k[1:0]]}, 8'h1F);
      rchk(8'h10 + k, 8'h3E);
    end
  endtask
  task t_staged;
    host.wr(8'h05, 8'h00);
    host.wr(8'h04, 8'hBF);
    host.wr(8'h05, 8'h0B);
    host.wr(8'h06, 8'h80);
    settle;
    chk(chan, 8'h0F);
    step_cycle;
    chk(n[7:0], 8'h08);
    @(posedge mclk) #1;
    chk(chan, 8'hBF);
    chk({s_start, s_end}, 8'h0B);
    chk({7'h00, alt}, 8'h01);
    chk({7'h00, rev}, 8'h00);
    chk({3'h0, drv, slot}, 8'h10);
    host.wr(8'h05, 8'hB0);
    step_cycle;
    chk(n[7:0], 8'h16);
    @(posedge mclk) #1;
    chk({s_start, s_end}, 8'hB0);
    chk({7'h00, rev}, 8'h01);
    chk({7'h00, drv}, 8'h00);
  endtask
  task t_lock;
    host.wr(8'h24, 8'h02);
    chk({7'h00, wr_allowed}, 8'h00);
    host.wr(8'h07, 8'h01);
    host.wr(8'h08, 8'h03);
    settle;
    chk({6'h00, ofs}, 8'h03);
    chk({4'h0, cm}, 8'h07);
    rchk(8'h07, 8'h03);
    do_reset;
    rchk(8'h24, 8'h00);
    host.wr(8'h24, 8'h01);
    chk({7'h00, bus_respond}, 8'h00);
    host.rd(8'h08, d, v);
    chk({7'h00, v}, 8'h00);
  endtask
  task print_verdict;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    step = 1'b0;
    repeat (3) @(posedge mclk);
    #1 rstn = 1'b1;
    t_defaults;
    t_immediate;
    t_staged;
    t_lock;
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
